// *** hdl/test_mode_key_dispatcher.sv ***
`timescale 1ns/1ns
// Test-mode key dispatcher for a weight indicator front panel
module test_mode_key_dispatcher
  import test_mode_pkg::*;
#(
  parameter int HOLD_CYCLES = SETUP_HOLD_CYCLES,
  parameter logic [AOUT_W-1:0] AOUT_ZERO = 14'h0000,
  parameter logic [AOUT_W-1:0] AOUT_FULL = 14'h3FFF
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic setup_switch,
  input wire logic [KEY_W-1:0] key_code,
  input wire logic [IO_COUNT-1:0] digital_in_n,
  input wire logic [ADC_W-1:0] adc_raw,
  input wire logic [AOUT_W-1:0] aout_normal,
  input wire logic [IO_COUNT-1:0] dout_normal,
  output logic test_active,
  output logic [IO_COUNT-1:0] digital_out,
  output logic [AOUT_W-1:0] analog_out,
  output display_type display,
  output service_cmd_type service_cmd,
  output logic cal_both_clear
);

  typedef enum logic [1:0] {
    ST_NORMAL = 2'b00,
    ST_ARMING = 2'b01,
    ST_TEST = 2'b10,
    ST_WAIT_SETUP_UP = 2'b11
  } state_type;

  state_type state_reg;
  logic [31:0] hold_count_reg;
  logic setup_s;
  logic [IO_COUNT-1:0] din_s;
  logic [KEY_W-1:0] key_s;
  logic [KEY_W-1:0] key_prev_reg;
  logic key_new;
  logic io_key;
  logic [2:0] io_index;
  logic in_test;

  // Pin inputs pass two flops first
  sync2 #(.WIDTH(1)) sync_setup (
    .clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en),
    .async_in(setup_switch), .sync_out(setup_s)
  );
  sync2 #(.WIDTH(IO_COUNT)) sync_din (
    .clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en),
    .async_in(digital_in_n), .sync_out(din_s)
  );
  sync2 #(.WIDTH(KEY_W)) sync_key (
    .clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en),
    .async_in(key_code), .sync_out(key_s)
  );

  // Key press edge detection
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      key_prev_reg <= KEY_NONE;
    end else if (clk_en) begin
      key_prev_reg <= key_s;
    end
  end

  assign key_new = (key_s != KEY_NONE) && (key_s != key_prev_reg);
  assign in_test = (state_reg == ST_TEST) || (state_reg == ST_WAIT_SETUP_UP);
  assign io_key = (key_s >= KEY_IO_FIRST) && (key_s <= KEY_IO_LAST);
  assign io_index = 3'(key_s - KEY_IO_FIRST);

  // Mode sequencing: entry by held setup switch, exit by key three
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_reg <= ST_NORMAL;
      hold_count_reg <= '0;
    end else if (clk_en) begin
      unique case (state_reg)
        ST_NORMAL: begin
          hold_count_reg <= '0;
          if (setup_s) begin
            state_reg <= ST_ARMING;
          end
        end
        ST_ARMING: begin
          if (!setup_s) begin
            state_reg <= ST_NORMAL;
          end else if (hold_count_reg >= 32'(HOLD_CYCLES - 1)) begin
            state_reg <= ST_WAIT_SETUP_UP;
          end else begin
            hold_count_reg <= hold_count_reg + 32'h1;
          end
        end
        ST_WAIT_SETUP_UP: begin
          // Entry hold must not count as a service combination
          if (!setup_s) begin
            state_reg <= ST_TEST;
          end
        end
        ST_TEST: begin
          if (key_new && key_s == KEY_DIGIT3 && !setup_s) begin
            state_reg <= ST_NORMAL;
          end
        end
      endcase
    end
  end

  assign test_active = in_test;

  // Digital output forcing, all low in test mode without an io key, normal outputs outside test mode
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      digital_out <= '0;
    end else if (clk_en) begin
      if (state_reg == ST_TEST && io_key && !setup_s) begin
        digital_out <= dout_normal | (IO_COUNT'(1) << io_index);
      end else if (in_test) begin
        digital_out <= '0;
      end else begin
        digital_out <= dout_normal;
      end
    end
  end

  // Analog output forcing
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      analog_out <= AOUT_ZERO;
    end else if (clk_en) begin
      if (state_reg == ST_TEST && key_s == KEY_F1 && !setup_s) begin
        analog_out <= AOUT_ZERO;
      end else if (state_reg == ST_TEST && key_s == KEY_F2 && !setup_s) begin
        analog_out <= AOUT_FULL;
      end else begin
        analog_out <= aout_normal;
      end
    end
  end

  // Display selection
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      display <= '{mode: SHOW_NORMAL, input_index: ZERO3, value: '0};
    end else if (clk_en) begin
      display.input_index <= ZERO3;
      display.value <= '0;
      if (!in_test) begin
        display.mode <= SHOW_NORMAL;
      end else if (state_reg == ST_WAIT_SETUP_UP) begin
        display.mode <= SHOW_TEST;
      end else if (setup_s) begin
        display.mode <= SHOW_BUSY;
      end else if (io_key) begin
        // Inputs are active low at the pin
        display.mode <= din_s[io_index] ? SHOW_INPUT_LO : SHOW_INPUT_HI;
        display.input_index <= io_index;
      end else if (key_s == KEY_F1) begin
        display.mode <= SHOW_AOUT_ZERO;
      end else if (key_s == KEY_F2) begin
        display.mode <= SHOW_AOUT_FULL;
      end else if (key_s == KEY_DIGIT7) begin
        display.mode <= SHOW_RAW_ADC;
        display.value <= adc_raw;
      end else begin
        display.mode <= SHOW_TEST;
      end
    end
  end

  // Service commands: one pulse per press with setup switch held
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      service_cmd <= '0;
      cal_both_clear <= 1'b0;
    end else if (clk_en) begin
      service_cmd <= '0;
      cal_both_clear <= 1'b0;
      if (state_reg == ST_TEST && setup_s && key_new) begin
        unique case (key_s)
          KEY_ENTER: service_cmd.battery_ram_wipe <= 1'b1;
          KEY_DIGIT0: service_cmd.factory_defaults <= 1'b1;
          KEY_POINT: begin
            service_cmd.eeprom_erase <= 1'b1;
            cal_both_clear <= 1'b1;
          end
          KEY_DIGIT8: service_cmd.adc_zero_point_cal <= 1'b1;
          KEY_DIGIT9: service_cmd.adc_span_cal <= 1'b1;
          default: service_cmd <= '0;
        endcase
      end
    end
  end

  // Checks on the dispatcher's own outputs
  AST_EXIT_ON_THREE: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (clk_en && state_reg == ST_TEST && key_new && key_s == KEY_DIGIT3 && !setup_s) |=> !test_active)
    else $error("key three did not leave test mode");
  AST_IO_FORCE: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (clk_en && state_reg == ST_TEST && io_key && !setup_s) |=> digital_out[$past(io_index)])
    else $error("held io key did not drive its output");
  AST_AOUT_ZERO: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (clk_en && state_reg == ST_TEST && key_s == KEY_F1 && !setup_s) |=> analog_out == AOUT_ZERO)
    else $error("F1 did not force analog zero");
  AST_AOUT_FULL: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (clk_en && state_reg == ST_TEST && key_s == KEY_F2 && !setup_s) |=> analog_out == AOUT_FULL)
    else $error("F2 did not force analog full scale");
  AST_RAW_ADC: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (clk_en && state_reg == ST_TEST && key_s == KEY_DIGIT7 && !setup_s) |=>
    display.mode == SHOW_RAW_ADC && display.value == $past(adc_raw))
    else $error("raw count not shown");
  AST_RAM_WIPE: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (clk_en && state_reg == ST_TEST && setup_s && key_new && key_s == KEY_ENTER) |=>
    service_cmd.battery_ram_wipe ##1 (!service_cmd.battery_ram_wipe || !$past(clk_en)))
    else $error("ram wipe not a single pulse");
  AST_EEPROM_BOTH: assert property (@(posedge clk_sys) disable iff (!rst_n)
    service_cmd.eeprom_erase == cal_both_clear)
    else $error("eeprom erase without calibration clear");
  AST_NO_CMD_OUTSIDE: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (!test_active) |-> ##1 (service_cmd == '0) || $past(state_reg == ST_TEST))
    else $error("service command outside test mode");
  AST_INPUT_SHOWN: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (clk_en && state_reg == ST_TEST && io_key && !setup_s) |=>
    display.input_index == $past(io_index) && display.mode == ($past(din_s[io_index]) ? SHOW_INPUT_LO : SHOW_INPUT_HI))
    else $error("input state not shown");

endmodule : test_mode_key_dispatcher

// *** common/test_mode_pkg.sv ***
// Package for the test-mode key dispatcher: key codes, display codes, timing
package test_mode_pkg;

  localparam int KEY_W = 5;
  localparam int IO_COUNT = 8;
  localparam int ADC_W = 24;
  localparam int AOUT_W = 14;

  // Key codes as delivered by the keypad scanner
  localparam logic [4:0] KEY_NONE = 5'h00;
  localparam logic [4:0] KEY_IO_FIRST = 5'h01;
  localparam logic [4:0] KEY_IO_LAST = 5'h08;
  localparam logic [4:0] KEY_F1 = 5'h09;
  localparam logic [4:0] KEY_F2 = 5'h0A;
  localparam logic [4:0] KEY_DIGIT0 = 5'h10;
  localparam logic [4:0] KEY_DIGIT3 = 5'h13;
  localparam logic [4:0] KEY_DIGIT7 = 5'h17;
  localparam logic [4:0] KEY_DIGIT8 = 5'h18;
  localparam logic [4:0] KEY_DIGIT9 = 5'h19;
  localparam logic [4:0] KEY_POINT = 5'h1A;
  localparam logic [4:0] KEY_ENTER = 5'h1B;

  // Setup switch hold time before test mode is entered
  localparam int SETUP_HOLD_MS = 2;
  localparam int CLK_MHZ = 100;
  localparam int SETUP_HOLD_CYCLES = SETUP_HOLD_MS * 1000 * CLK_MHZ;

  localparam logic [2:0] ZERO3 = 3'h0;
  localparam logic [7:0] ZERO8 = 8'h00;

  // What the display shows
  typedef enum logic [3:0] {
    SHOW_NORMAL = 4'b0000,
    SHOW_TEST = 4'b0001,
    SHOW_INPUT_HI = 4'b0010,
    SHOW_INPUT_LO = 4'b0011,
    SHOW_AOUT_ZERO = 4'b0100,
    SHOW_AOUT_FULL = 4'b0101,
    SHOW_RAW_ADC = 4'b0110,
    SHOW_BUSY = 4'b0111
  } show_type;

  // One-shot service commands toward memories and converter
  typedef struct packed {
    logic battery_ram_wipe;
    logic factory_defaults;
    logic eeprom_erase;
    logic adc_zero_point_cal;
    logic adc_span_cal;
  } service_cmd_type;

  // Display word
  typedef struct packed {
    show_type mode;
    logic [2:0] input_index;
    logic [23:0] value;
  } display_type;

endpackage : test_mode_pkg

// *** hdl/sync2.sv ***
`timescale 1ns/1ns
// Two-flop synchroniser, one per bit of a bus
module sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1_reg;

  // First stage feeds only the second
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      stage1_reg <= '0;
      sync_out <= '0;
    end else if (clk_en) begin
      stage1_reg <= async_in;
      sync_out <= stage1_reg;
    end
  end
endmodule : sync2

// *** tb/keypad_model.sv ***
// Operator keypad and setup switch model for the test-mode dispatcher
`timescale 1ns/1ns
module keypad_model
  import test_mode_pkg::*;
(
  input wire logic clk_sys,
  input wire logic want_setup,
  input wire logic [KEY_W-1:0] want_key,
  output logic setup_switch,
  output logic [KEY_W-1:0] key_code
);
  // Idle operator at power-up
  initial begin
    setup_switch = 1'b0;
    key_code = KEY_NONE;
  end

  // Operator action lands one edge after it is asked for
  always @(posedge clk_sys) begin
    setup_switch <= want_setup; // Held as long as asked
    key_code <= want_key;
  end
endmodule : keypad_model

// *** tb/tb_top.sv ***
// Self-checking bench for the test-mode key dispatcher
`timescale 1ns/1ns
module tb_top;
  import test_mode_pkg::*;
  localparam logic [AOUT_W-1:0] AZ = 14'h0123;
  localparam logic [AOUT_W-1:0] AF = 14'h3F00;
  localparam logic [4:0] SVC_KEY [5] = '{KEY_ENTER, KEY_DIGIT0, KEY_POINT, KEY_DIGIT8, KEY_DIGIT9};
  logic clk_sys, rst_n, clk_en, want_setup, setup_switch, test_active, cal_both_clear;
  logic [KEY_W-1:0] want_key, key_code;
  logic [IO_COUNT-1:0] digital_in_n, dout_normal, digital_out;
  logic [ADC_W-1:0] adc_raw;
  logic [AOUT_W-1:0] aout_normal, analog_out;
  logic [31:0] lfsr_state = 32'h000165CD;
  display_type display;
  service_cmd_type service_cmd;
  int n_mismatch = 0;
  int samples_checked = 0;
  int cycles = 0;
  int pulses[6] = '{default: 0};
  int base[6];

  keypad_model operator_side (.clk_sys(clk_sys), .want_setup(want_setup), .want_key(want_key),
    .setup_switch(setup_switch), .key_code(key_code));

  test_mode_key_dispatcher #(.HOLD_CYCLES(4), .AOUT_ZERO(AZ), .AOUT_FULL(AF)) uut (
    .clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en), .setup_switch(setup_switch), .key_code(key_code),
    .digital_in_n(digital_in_n), .adc_raw(adc_raw), .aout_normal(aout_normal), .dout_normal(dout_normal),
    .test_active(test_active), .digital_out(digital_out), .analog_out(analog_out), .display(display),
    .service_cmd(service_cmd), .cal_both_clear(cal_both_clear));

  // 100 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // Pulse tally per service command, plus the both-calibrations flag
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 2000) begin
      n_mismatch++;
      conclude();
    end
    if (rst_n === 1'b1) begin
      for (int i = 0; i < 5; i++) pulses[i] += int'(service_cmd[i] === 1'b1);
      pulses[5] += int'(cal_both_clear === 1'b1);
    end
  end

  function automatic logic [31:0] lfsr_next(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next

  // Ask the operator for an action, refresh random inputs, then let n edges pass
  task automatic apply(logic s, logic [4:0] k, int n);
    @(posedge clk_sys);
    lfsr_state = lfsr_next(lfsr_next(lfsr_state));
    want_setup <= s;
    want_key <= k;
    digital_in_n <= lfsr_state[7:0];
    dout_normal <= lfsr_state[15:8];
    adc_raw <= lfsr_state[31:8];
    aout_normal <= lfsr_state[29:16];
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : apply

  task automatic chk_val(logic [23:0] got, logic [23:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t value got %h exp %h", $time, got, exp);
    end
  endtask : chk_val

  task automatic chk_show(show_type got, show_type exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t display got %b exp %b", $time, got, exp);
    end
  endtask : chk_show

  task automatic conclude;
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : conclude

  // Main sequence
  initial begin
    rst_n = 1'b0;
    clk_en = 1'b1;
    want_setup = 1'b0;
    want_key = KEY_NONE;
    digital_in_n = 8'hFF;
    dout_normal = 8'h00;
    adc_raw = 24'h000000;
    aout_normal = 14'h0000;
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    // Too short a hold must not enter
    apply(1'b1, KEY_NONE, 2);
    apply(1'b0, KEY_NONE, 6);
    chk_val(24'(test_active), 24'h000000);
    apply(1'b1, KEY_NONE, 10);
    chk_val(24'(test_active), 24'h000001);
    chk_show(display.mode, SHOW_TEST);
    apply(1'b0, KEY_NONE, 6);
    // Every digital probe key, then release
    for (int k = 1; k <= 8; k++) begin
      apply(1'b0, KEY_W'(k), 6);
      chk_val(24'(digital_out), 24'(dout_normal | (8'h01 << (k - 1))));
      chk_val(24'(digital_out[k-1]), 24'h000001);
      chk_show(display.mode, digital_in_n[k-1] ? SHOW_INPUT_LO : SHOW_INPUT_HI);
      chk_val(24'(display.input_index), 24'(k - 1));
      apply(1'b0, KEY_NONE, 6);
      chk_val(24'(digital_out), 24'h000000);
      chk_show(display.mode, SHOW_TEST);
    end
    // Analog forcing and raw converter count
    apply(1'b0, KEY_F1, 6);
    chk_val(24'(analog_out), 24'(AZ));
    // Clock enable low freezes the forced state although the key changes
    @(posedge clk_sys);
    clk_en <= 1'b0;
    apply(1'b0, KEY_F2, 6);
    chk_val(24'(analog_out), 24'(AZ));
    chk_show(display.mode, SHOW_AOUT_ZERO);
    @(posedge clk_sys);
    clk_en <= 1'b1;
    apply(1'b0, KEY_F2, 6);
    chk_val(24'(analog_out), 24'(AF));
    apply(1'b0, KEY_DIGIT7, 6);
    chk_show(display.mode, SHOW_RAW_ADC);
    chk_val(display.value, adc_raw);
    apply(1'b0, KEY_NONE, 6);
    chk_val(24'(analog_out), 24'(aout_normal));
    // Service key without the setup switch is refused
    base = pulses;
    apply(1'b0, KEY_ENTER, 6);
    apply(1'b0, KEY_NONE, 4);
    chk_val(24'(pulses[4] - base[4]), 24'h000000);
    // Each service combination gives exactly its own single pulse
    for (int j = 0; j < 5; j++) begin
      base = pulses;
      apply(1'b1, KEY_NONE, 3);
      apply(1'b1, SVC_KEY[j], 6);
      apply(1'b1, KEY_NONE, 3);
      apply(1'b0, KEY_NONE, 4);
      for (int i = 0; i < 5; i++) chk_val(24'(pulses[i] - base[i]), 24'(i == 4 - j));
      chk_val(24'(pulses[5] - base[5]), 24'(j == 2));
    end
    apply(1'b0, KEY_DIGIT3, 6);
    chk_val(24'(test_active), 24'h000000);
    chk_show(display.mode, SHOW_NORMAL);
    apply(1'b0, KEY_NONE, 2);
    chk_val(24'(digital_out), 24'(dout_normal));
    conclude();
  end
endmodule : tb_top
